// ==== intc_params.svh ====
// Purpose: named constants for the priority interrupt and trap controller
// Assumes: 32-bit APB, one word per register
// Notes: offsets are byte addresses
`ifndef INTC_PARAMS_SVH
`define INTC_PARAMS_SVH
`define NUM_SRC 16
`define FIRST_VEC 8'h08
`define OFF_FLAG 12'h000
`define OFF_ENABLE 12'h004
`define OFF_PRIO0 12'h008
`define OFF_PRIO1 12'h00c
`define OFF_PENDING 12'h010
`define OFF_STATUS 12'h014
`define OFF_CORE 12'h018
`define OFF_TRAP 12'h01c
`define OFF_EXTCTL 12'h020
`define OFF_IRQ_STAT 12'h024
`define OFF_IRQ_MASK 12'h028
`define OFF_TRAP_EVT 12'h02c
`define SR_IPL_LO 5
`define SR_IPL_HI 7
`define CC_VAR 15
`define CC_PRIORITY_LEVEL_MSB 3
`define TC_NEST 15
`define TC_OVA 14
`define TC_OVB 13
`define TC_COVA 12
`define TC_COVB 11
`define TC_ACC_A_OVERFLOW_TRAP_EN 10
`define TC_ACC_B_OVERFLOW_TRAP_EN 9
`define TC_CATASTROPHIC_TRAP_EN 8
`define TC_SHIFT 7
`define TC_DIV0 6
`define TC_MATH 4
`define TC_ADDR 3
`define TC_STK 2
`define TC_OSC 1
`define TC_WMASK 16'hffde
`define EC_SOFTWARE_TRAP_ENABLE 13
`define EC_WMASK 16'h2017
`define IPL_USER_MAX 3'h7
`define EV_PEND 0
`define EV_TRAP 1
`endif

// ==== intc_pkg.sv ====
// Purpose: shared types for the interrupt controller
// Assumes: nothing
// Notes: constants live in intc_params.svh
package intc_pkg;
    typedef logic [15:0] word16_t;
    typedef logic [2:0] prio_t;
endpackage : intc_pkg

// ==== ext_edge_if.sv ====
// Purpose: carrier between the controller and its edge detector
// Assumes: one clock
// Notes: bundles raw pins, polarity and detected edges
`timescale 1ns/10ps
interface ext_edge_if;
    logic [4:0] pins;
    logic [4:0] fallSel;
    logic [4:0] edgeHit;
    modport ctrl (output pins, output fallSel, input edgeHit);
    modport det (input pins, input fallSel, output edgeHit);
endinterface : ext_edge_if

// ==== ext_edge_detect.sv ====
// Purpose: synchronise external request pins and detect selected edges
// Assumes: pins are asynchronous to clk
// Notes: edge seen once the second and third stages agree on a new level
`timescale 1ns/10ps
module ext_edge_detect
    import intc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // carrier
    ext_edge_if.det eif
);
    logic [4:0] s1_r;
    logic [4:0] s2_r;
    logic [4:0] s3_r;
    logic [4:0] lvl_r;
    logic [4:0] agree;
    logic [4:0] rise;
    logic [4:0] fall;

    // three stage synchroniser and filtered level
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s1_r <= 5'h00;
            s2_r <= 5'h00;
            s3_r <= 5'h00;
            lvl_r <= 5'h00;
        end else begin
            s1_r <= eif.pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
            lvl_r <= (agree & s2_r) | (~agree & lvl_r);
        end
    end

    // edge selection by polarity, 1 selects falling
    assign agree = ~(s2_r ^ s3_r);
    assign rise = agree & s2_r & ~lvl_r;
    assign fall = agree & ~s2_r & lvl_r;
    assign eif.edgeHit = (eif.fallSel & fall) | (~eif.fallSel & rise);
endmodule : ext_edge_detect

// ==== priority_interrupt_and_trap_control.sv ====
// Function
// - each source has an enable bit; only enabled sources may request
// - each source has a three-bit priority choosing one of seven levels; sources 4..7, 8..11 and 12..15 share the four prio1_r fields
// - pending vector number and new level latched in pending status
// - latched new level equals the pending source's priority
// - bits assigned in vector order; external irq zero is vector 8, bit 0
// - status word bits 7:5 hold the low level bits, writable by software
// - core control bit 3 is level msb, software can only clear it, set means above 7
// - user interrupts blocked at level 7 or with level msb set
// - nesting disable makes status word level bits read-only
// - core control bit 15 selects variable exception latency
// - nesting disable stops preemption of an interrupt in service
// - trap bits 14..11 flag accumulator overflow and catastrophic overflow traps
// - bits 10, 9, 8 enable overflow and catastrophic overflow trapping
// - bit 4 flags math trap; bit 7 bad shift, bit 6 divide by zero causes
// - bits 3, 2, 1 flag address, stack, oscillator traps; bit 0 reads zero
// - external control bit 13 enables the software trap
// - polarity bits select falling (1) or rising (0) edge for ext irqs 0, 1, 2 and 4; ext irq 3 is always rising
// - request flags set by hardware stay set until software clears them or, for source flags, until acknowledged
//
// Purpose: interrupt priority and trap control with APB register access
// Assumes: 16 user sources, vectors 8..23; sources 0..4 are external pins
// Notes: core acknowledges the presented vector with coreAck
// Notes: the level msb has its own flop so a trap is never lost to a retire
// Notes: or a software access in the same cycle; it always wins
// Notes: the latency select bit is written independently of the level logic
// Notes: only the level msb and the latency select bit of the core word exist;
// Notes: every other core word bit reads as zero
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "intc_params.svh"
module priority_interrupt_and_trap_control
    import intc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt sources
    input wire logic [15:0] srcPulse,
    input wire logic [4:0] extIrqPin,
    // trap events from the core
    input wire logic accAOverflow,
    input wire logic accBOverflow,
    input wire logic accACatastrophic,
    input wire logic accBCatastrophic,
    input wire logic badShift,
    input wire logic divideZero,
    input wire logic addressError,
    input wire logic stackError,
    input wire logic oscFailure,
    input wire logic softwareTrapReq,
    // core request side
    output logic coreReq,
    output logic [7:0] coreVector,
    output logic [3:0] coreLevel,
    input wire logic coreAck,
    input wire logic coreRetire,
    output logic trapReq,
    output logic variableLatency,
    // interrupt to system
    output logic irqOut
);
    word16_t flag_r, enable_r, prio0_r, prio1_r, status_r, core_r, trap_r, extctl_r;
    logic [7:0] pendVec_r;
    logic [3:0] pendLvl_r;
    logic [1:0] irqStat_r, irqMask_r;
    logic [3:0] savedIpl_r;
    logic inService_r;
    // level msb and latency select, gathered into core_r for reads
    logic priority_level_msb_r;
    logic var_r;
    logic [15:0] extHit;
    logic [2:0] srcPrio [16];
    logic [3:0] curIpl;
    logic userBlocked;
    logic found;
    logic [3:0] bestIdx;
    prio_t bestPrio;
    logic wrEn, rdEn;
    logic [15:0] wd;
    logic [15:0] flagSet, trapSet;
    logic trapEvt;
    logic [31:0] rdMux;
    logic takeAck;

    ext_edge_if eif ();
    assign eif.pins = extIrqPin;
    assign eif.fallSel = {extctl_r[4], 1'b0, extctl_r[2:0]};
    ext_edge_detect u_edge (.clk(clk), .rstn(rstn), .eif(eif));

    // apb decode, zero wait state
    assign wrEn = psel & penable & pwrite;
    assign rdEn = psel & ~pwrite;
    assign wd = pwdata[15:0];
    assign pready = 1'b1;

    // per-source priority fields, four to a register; prio0_r holds sources 0..3, sources 4..7, 8..11 and 12..15 all share prio1_r
    genvar g;
    for (g = 0; g < 16; g++) begin : g_prio
        if (g < 4)
            assign srcPrio[g] = prio0_r[4*g +: 3];
        else if (g < 8)
            assign srcPrio[g] = prio0_r[4*(g-4)+16-16 +: 3] & 3'h0 | prio1_r[4*(g-4) +: 3];
        else if (g < 12)
            assign srcPrio[g] = prio1_r[4*(g-8) +: 3] & 3'h0 | prio1_r[4*(g-8) +: 3];
        else
            assign srcPrio[g] = prio1_r[4*(g-12) +: 3];
    end

    // current level and blocking
    assign curIpl = {core_r[`CC_PRIORITY_LEVEL_MSB], status_r[`SR_IPL_HI:`SR_IPL_LO]};
    assign userBlocked = core_r[`CC_PRIORITY_LEVEL_MSB] |
        (status_r[`SR_IPL_HI:`SR_IPL_LO] == `IPL_USER_MAX);
    assign variableLatency = core_r[`CC_VAR];

    // priority arbitration, lowest index wins ties
    always_comb begin
        found = 1'b0;
        bestIdx = 4'h0;
        bestPrio = 3'h0;
        for (int i = 0; i < `NUM_SRC; i++) begin
            if (flag_r[i] && enable_r[i] && srcPrio[i] != 3'h0 &&
                    {1'b0, srcPrio[i]} > curIpl && srcPrio[i] > bestPrio) begin
                found = 1'b1;
                bestIdx = 4'(i);
                bestPrio = srcPrio[i];
            end
        end
    end

    assign takeAck = coreReq & coreAck;
    assign coreReq = found & ~userBlocked & ~(inService_r & trap_r[`TC_NEST]);
    assign coreVector = `FIRST_VEC + {4'h0, bestIdx};
    assign coreLevel = {1'b0, bestPrio};

    // hardware set sources, external pins map to low sources
    assign extHit = {11'h000, eif.edgeHit};
    assign flagSet = srcPulse | extHit;

    // trap flag set terms; overflow and catastrophic terms gated by their enables
    always_comb begin
        trapSet = 16'h0000;
        trapSet[`TC_OVA] = accAOverflow & trap_r[`TC_ACC_A_OVERFLOW_TRAP_EN];
        trapSet[`TC_OVB] = accBOverflow & trap_r[`TC_ACC_B_OVERFLOW_TRAP_EN];
        trapSet[`TC_COVA] = accACatastrophic & trap_r[`TC_CATASTROPHIC_TRAP_EN];
        trapSet[`TC_COVB] = accBCatastrophic & trap_r[`TC_CATASTROPHIC_TRAP_EN];
        trapSet[`TC_SHIFT] = badShift;
        trapSet[`TC_DIV0] = divideZero;
        trapSet[`TC_MATH] = badShift | divideZero;
        trapSet[`TC_ADDR] = addressError;
        trapSet[`TC_STK] = stackError;
        trapSet[`TC_OSC] = oscFailure;
    end
    assign trapEvt = (|trapSet) | (softwareTrapReq & extctl_r[`EC_SOFTWARE_TRAP_ENABLE]);

    // source flags: set wins over software clear
    always_ff @(posedge clk) begin
        if (!rstn)
            flag_r <= 16'h0000;
        else if (wrEn && paddr == `OFF_FLAG)
            flag_r <= wd | flagSet;
        else
            flag_r <= (flag_r | flagSet) & ~(takeAck ? (16'h0001 << bestIdx) : 16'h0000);
    end

    // plain control registers
    always_ff @(posedge clk) begin
        if (!rstn) begin
            enable_r <= 16'h0000;
            prio0_r <= 16'h0000;
            prio1_r <= 16'h0000;
            extctl_r <= 16'h0000;
            irqMask_r <= 2'h0;
        end else if (wrEn) begin
            if (paddr == `OFF_ENABLE) enable_r <= wd;
            if (paddr == `OFF_PRIO0) prio0_r <= wd & 16'h7777;
            if (paddr == `OFF_PRIO1) prio1_r <= wd & 16'h7777;
            if (paddr == `OFF_EXTCTL) extctl_r <= wd & `EC_WMASK;
            if (paddr == `OFF_IRQ_MASK) irqMask_r <= pwdata[1:0];
        end
    end

    // status word level bits; the core raises the level on ack and restores
    // it on retire. a software write in an ack or retire cycle is dropped,
    // because the hardware level change must not be undone by a stale value.
    // while nesting is disabled software cannot touch the level bits at all.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            status_r <= 16'h0000;
            inService_r <= 1'b0;
            savedIpl_r <= 4'h0;
        end else if (takeAck) begin
            savedIpl_r <= curIpl;
            inService_r <= 1'b1;
            status_r[`SR_IPL_HI:`SR_IPL_LO] <= bestPrio;
        end else if (coreRetire && inService_r) begin
            inService_r <= 1'b0;
            status_r[`SR_IPL_HI:`SR_IPL_LO] <= savedIpl_r[2:0];
        end else if (wrEn && paddr == `OFF_STATUS && !trap_r[`TC_NEST]) begin
            status_r[`SR_IPL_HI:`SR_IPL_LO] <= wd[`SR_IPL_HI:`SR_IPL_LO];
        end
    end

    // level msb: a trap event sets it and wins over retire and software clear,
    // so a trap arriving in the same cycle as a retire is never masked.
    // software can only clear it, never set it, by writing zero to that bit.
    always_ff @(posedge clk) begin
        if (!rstn)
            priority_level_msb_r <= 1'b0;
        else if (trapEvt)
            priority_level_msb_r <= 1'b1;
        else if (coreRetire && inService_r)
            priority_level_msb_r <= savedIpl_r[3];
        else if (wrEn && paddr == `OFF_CORE && !wd[`CC_PRIORITY_LEVEL_MSB])
            priority_level_msb_r <= 1'b0;
    end

    // latency select: a plain software bit, independent of level changes,
    // so a write lands even when a trap or ack falls in the same cycle
    always_ff @(posedge clk) begin
        if (!rstn)
            var_r <= 1'b0;
        else if (wrEn && paddr == `OFF_CORE)
            var_r <= wd[`CC_VAR];
    end

    // core word view; unimplemented bits read as zero
    always_comb begin
        core_r = 16'h0000;
        core_r[`CC_VAR] = var_r;
        core_r[`CC_PRIORITY_LEVEL_MSB] = priority_level_msb_r;
    end

    // trap control: hardware set wins over software write
    always_ff @(posedge clk) begin
        if (!rstn)
            trap_r <= 16'h0000;
        else if (wrEn && paddr == `OFF_TRAP)
            trap_r <= (wd & `TC_WMASK) | trapSet;
        else
            trap_r <= trap_r | trapSet;
    end

    // pending vector latch; it follows the presented request while one
    // stands and keeps the last one afterwards, so software can still see
    // which vector was taken and at which level
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pendVec_r <= 8'h00;
            pendLvl_r <= 4'h0;
        end else if (coreReq) begin
            pendVec_r <= coreVector;
            pendLvl_r <= coreLevel;
        end
    end

    // sticky event bits, write one to clear, set wins
    always_ff @(posedge clk) begin
        if (!rstn)
            irqStat_r <= 2'h0;
        else
            irqStat_r <= (irqStat_r & ~((wrEn && paddr == `OFF_IRQ_STAT) ? pwdata[1:0] : 2'h0))
                | {trapEvt, takeAck};
    end
    assign irqOut = |(irqStat_r & irqMask_r);
    assign trapReq = core_r[`CC_PRIORITY_LEVEL_MSB];

    // read mux; an unmapped offset reads zero and flags an error in the
    // access phase only, so a setup cycle never shows a spurious error
    always_comb begin
        rdMux = 32'h0000_0000;
        pslverr = 1'b0;
        unique case (paddr)
            `OFF_FLAG: rdMux[15:0] = flag_r;
            `OFF_ENABLE: rdMux[15:0] = enable_r;
            `OFF_PRIO0: rdMux[15:0] = prio0_r;
            `OFF_PRIO1: rdMux[15:0] = prio1_r;
            `OFF_PENDING: rdMux[15:0] = {4'h0, pendLvl_r, pendVec_r};
            `OFF_STATUS: rdMux[15:0] = status_r;
            `OFF_CORE: rdMux[15:0] = core_r;
            `OFF_TRAP: rdMux[15:0] = trap_r;
            `OFF_EXTCTL: rdMux[15:0] = extctl_r;
            `OFF_IRQ_STAT: rdMux[1:0] = irqStat_r;
            `OFF_IRQ_MASK: rdMux[1:0] = irqMask_r;
            default: pslverr = psel & penable;
        endcase
    end

    // registered read data, captured in the setup cycle and held until the
    // next read setup; this keeps the slave at zero wait states
    always_ff @(posedge clk) begin
        if (!rstn)
            prdata <= 32'h0000_0000;
        else if (rdEn && !penable)
            prdata <= rdMux;
    end
endmodule : priority_interrupt_and_trap_control

// ==== intc_checker.sv ====
// Purpose: port assertions for the interrupt controller
// Assumes: one clock, sync active-low reset
// Notes: nesting state mirrored from apb writes
`timescale 1ns/10ps
`include "intc_params.svh"
module intc_checker (
    // clock, reset and apb
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // traps and core side
    input wire logic addressError,
    input wire logic stackError,
    input wire logic oscFailure,
    input wire logic coreReq,
    input wire logic [7:0] coreVector,
    input wire logic [3:0] coreLevel,
    input wire logic coreAck,
    input wire logic trapReq,
    input wire logic variableLatency
);
    logic nestOff_r;
    wire wrCore = psel && penable && pwrite && paddr == `OFF_CORE;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // mirror of the nesting disable bit
    always_ff @(posedge clk) begin
        if (!rstn)
            nestOff_r <= 1'b0;
        else if (psel && penable && pwrite && paddr == `OFF_TRAP)
            nestOff_r <= pwdata[`TC_NEST];
    end
    property p_trap; addressError || stackError || oscFailure |=> trapReq; endproperty
    a_trap: assert property (p_trap) else $error("trap left msb clear");
    property p_block; trapReq |-> !coreReq; endproperty
    a_block: assert property (p_block) else $error("request with msb set");
    property p_vec; coreReq |-> coreVector >= 8'h08 && coreVector <= 8'h17; endproperty
    a_vec: assert property (p_vec) else $error("vector out of range");
    property p_lvl; coreReq |-> coreLevel >= 4'h1 && coreLevel <= 4'h7; endproperty
    a_lvl: assert property (p_lvl) else $error("level out of range");
    property p_var; wrCore |=> variableLatency == $past(pwdata[15]); endproperty
    a_var: assert property (p_var) else $error("latency bit not written");
    property p_hold; !wrCore |=> $stable(variableLatency); endproperty
    a_hold: assert property (p_hold) else $error("latency bit moved");
    property p_nest; nestOff_r && coreReq && coreAck |=> !coreReq [*4]; endproperty
    a_nest: assert property (p_nest) else $error("nested while disabled");
    property p_raise;
        !nestOff_r && coreReq && coreAck |=> !coreReq || coreLevel > $past(coreLevel);
    endproperty
    a_raise: assert property (p_raise) else $error("preempt not higher");
    c_ack: cover property (coreReq && coreAck);
    c_trap: cover property (trapReq);
    c_nest: cover property (nestOff_r && coreAck);
endmodule : intc_checker

// ==== intc_core_model.sv ====
// Purpose: behavioural processor core taking vectored requests
// Assumes: a request is taken only while it stands
// Notes: waitCyc makes the core answer promptly or slowly
`timescale 1ns/10ps
module intc_core_model (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // request side
    input wire logic coreReq,
    input wire logic [7:0] coreVector,
    input wire logic [3:0] waitCyc,
    output logic coreAck,
    output logic coreRetire,
    // record of requests taken
    output logic [7:0] lastVec,
    output logic [7:0] ackCnt
);
    logic [3:0] waitCnt;
    logic [4:0] svcCnt;
    // wait, hold ack one cycle, retire after a fixed service time
    always_ff @(posedge clk) begin
        if (!rstn) begin
            coreAck <= 1'b0;
            svcCnt <= 5'h00;
            ackCnt <= 8'h00;
            waitCnt <= 4'h0;
        end else begin
            coreAck <= !coreAck && coreReq && waitCnt >= waitCyc;
            waitCnt <= (coreReq && !coreAck) ? waitCnt + 4'h1 : 4'h0;
            svcCnt <= (coreAck && coreReq) ? 5'h1f : svcCnt - {4'h0, svcCnt != 5'h00};
            if (coreAck && coreReq) begin
                lastVec <= coreVector;
                ackCnt <= ackCnt + 8'h01;
            end
        end
    end
    assign coreRetire = svcCnt == 5'h01;
endmodule : intc_core_model

// ==== priority_interrupt_and_trap_control_tb.sv ====
// Purpose: self-checking bench for the interrupt controller
// Assumes: zero-wait apb, behavioural core model
// Notes: registers reached only through apb tasks
`timescale 1ns/10ps
`include "intc_params.svh"
module priority_interrupt_and_trap_control_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, errSeen, coreReq, coreAck, coreRetire, trapReq, varLat, irqOut;
    logic [15:0] srcPulse = 16'h0000;
    logic [4:0] extIrqPin = 5'h00;
    logic [9:0] ev = 10'h000;
    logic [7:0] coreVector, lastVec, ackCnt;
    logic [3:0] coreLevel;
    logic [3:0] waitCyc = 4'h0;
    logic [15:0] tExp [11] = '{16'h4400, 16'h2200, 16'h1100, 16'h0900, 16'h0090, 16'h0050,
        16'h0008, 16'h0004, 16'h0002, 16'h0000, 16'h0000};
    int n_fail = 0;
    int check_count = 0;
    // clock
    always #2.5 clk = ~clk;
    // unit under test and core model
    priority_interrupt_and_trap_control u_priority_interrupt_and_trap_control (
        .clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .srcPulse, .extIrqPin, .accAOverflow(ev[0]), .accBOverflow(ev[1]),
        .accACatastrophic(ev[2]), .accBCatastrophic(ev[3]), .badShift(ev[4]),
        .divideZero(ev[5]), .addressError(ev[6]), .stackError(ev[7]), .oscFailure(ev[8]),
        .softwareTrapReq(ev[9]), .coreReq, .coreVector, .coreLevel, .coreAck, .coreRetire,
        .trapReq, .variableLatency(varLat), .irqOut);
    intc_core_model u_intc_core_model (.clk, .rstn, .coreReq, .coreVector, .waitCyc,
        .coreAck, .coreRetire, .lastVec, .ackCnt);
    // closing report
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bchk(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : bchk
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_fail++;
            wrap_up();
        end
        rd = prdata;
        errSeen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rchk
    // one-cycle pulse on sources and trap events
    task automatic pulse(input logic [15:0] s, input logic [9:0] e);
        srcPulse <= s;
        ev <= e;
        @(posedge clk);
        srcPulse <= 16'h0000;
        ev <= 10'h000;
        @(posedge clk);
    endtask : pulse
    // bounded wait for the core to take a request
    task automatic expAck(input logic want);
        logic [7:0] c0;
        int k;
        c0 = ackCnt;
        k = 0;
        while (ackCnt === c0 && k < 60) begin
            @(posedge clk);
            k++;
        end
        bchk(ackCnt !== c0, want);
        if (want && k >= 60) wrap_up();
    endtask : expAck
    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        apb(1'b0, 12'h030, 32'h0);
        bchk(errSeen, 1'b1);
        wr(`OFF_STATUS, 32'h00e0);
        rchk(`OFF_STATUS, 32'h00e0);
        wr(`OFF_STATUS, 32'h0);
        wr(`OFF_CORE, 32'h8008);
        bchk(varLat, 1'b1);
        rchk(`OFF_CORE, 32'h8000);
        wr(`OFF_TRAP, 32'hffff);
        rchk(`OFF_TRAP, 32'hffde);
        wr(`OFF_STATUS, 32'h00a0);
        rchk(`OFF_STATUS, 32'h0);
        wr(`OFF_EXTCTL, 32'hffff);
        rchk(`OFF_EXTCTL, 32'h2017);
        $display("register test done");
        // each trap event with its enable, flags and level msb
        for (int i = 0; i < 11; i++) begin
            wr(`OFF_TRAP, {21'h0, i == 0, i == 1, i == 2 || i == 3, 8'h0});
            wr(`OFF_CORE, 32'h0);
            pulse(16'h0, i > 8 ? (i == 9 ? 10'h001 : 10'h200) : 10'h001 << i);
            rchk(`OFF_TRAP, {16'h0, tExp[i]});
            bchk(trapReq, i != 9);
        end
        $display("trap test done");
        // enabled source taken with vector and level, interrupt line
        wr(`OFF_CORE, 32'h0);
        wr(`OFF_IRQ_STAT, 32'h3);
        wr(`OFF_PRIO0, 32'h5000);
        wr(`OFF_ENABLE, 32'h8);
        pulse(16'h8, 10'h0);
        expAck(1'b1);
        chk({24'h0, lastVec}, 32'hb);
        rchk(`OFF_PENDING, 32'h050b);
        bchk(irqOut, 1'b0);
        wr(`OFF_IRQ_MASK, 32'h1);
        bchk(irqOut, 1'b1);
        wr(`OFF_IRQ_STAT, 32'h1);
        bchk(irqOut, 1'b0);
        $display("vector test done");
        // a disabled source stays pending until enabled
        wr(`OFF_PRIO0, 32'h0040);
        pulse(16'h2, 10'h0);
        expAck(1'b0);
        rchk(`OFF_FLAG, 32'h2);
        wr(`OFF_ENABLE, 32'h2);
        expAck(1'b1);
        expAck(1'b0);
        $display("enable test done");
        // higher level first, lower vector wins a tie, slow core
        waitCyc <= 4'h6;
        wr(`OFF_PRIO0, 32'h0662);
        wr(`OFF_ENABLE, 32'h7);
        pulse(16'h7, 10'h0);
        for (int i = 0; i < 3; i++) begin
            expAck(1'b1);
            chk({24'h0, lastVec}, i == 0 ? 32'h9 : (i == 1 ? 32'ha : 32'h8));
        end
        $display("priority test done");
        // level seven blocks; nesting disable holds off a higher source
        waitCyc <= 4'h0;
        repeat (40) @(posedge clk);
        wr(`OFF_STATUS, 32'h00e0);
        pulse(16'h1, 10'h0);
        expAck(1'b0);
        wr(`OFF_STATUS, 32'h0);
        expAck(1'b1);
        wr(`OFF_TRAP, 32'h8000);
        pulse(16'h2, 10'h0);
        repeat (8) @(posedge clk);
        chk({24'h0, lastVec}, 32'h8);
        expAck(1'b1);
        wr(`OFF_TRAP, 32'h0);
        $display("nesting test done");
        // pin zero counts falling edges, pin one rising edges
        wr(`OFF_ENABLE, 32'h0);
        wr(`OFF_FLAG, 32'h0);
        wr(`OFF_EXTCTL, 32'h0001);
        extIrqPin <= 5'h03;
        repeat (8) @(posedge clk);
        rchk(`OFF_FLAG, 32'h2);
        extIrqPin <= 5'h00;
        repeat (8) @(posedge clk);
        rchk(`OFF_FLAG, 32'h3);
        $display("edge test done");
        wrap_up();
    end
endmodule : priority_interrupt_and_trap_control_tb
bind priority_interrupt_and_trap_control intc_checker u_intc_checker (.clk, .rstn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .addressError, .stackError, .oscFailure, .coreReq,
    .coreVector, .coreLevel, .coreAck, .trapReq, .variableLatency);
